//--- core/dmac_dly.sv
// control or data stage of zero, one or two registers
// assumes clear and enable come from the block's selected control set
module dmac_dly
  import dmac_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic clk_in, // block clock
  input wire logic reset_in, // synchronous reset
  input wire logic [1:0] stages_in, // 0, 1 or 2 register stages
  input wire logic ena_in, // selected clock enable
  input wire logic clr_in, // selected asynchronous clear
  input wire logic [W-1:0] d_in, // stage input
  output logic [W-1:0] q_out // delayed value
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;

  if (W < 1) begin : g_bad_width
    $error("dmac_dly width must be positive");
  end

  // clear acts at once, clock and enable play no part in it
  always_ff @(posedge clk_in or posedge clr_in) begin
    if (clr_in) begin
      s1_q <= '0;
      s2_q <= '0;
    end else if (reset_in) begin
      s1_q <= '0;
      s2_q <= '0;
    end else if (ena_in) begin
      s1_q <= d_in;
      s2_q <= s1_q;
    end
  end

  // stage count 3 is treated as 2
  assign q_out = (stages_in == 2'h0) ? d_in :
                 (stages_in == 2'h1) ? s1_q : s2_q;
endmodule

//--- core/dmac_mul.sv
// one full-precision multiplier with per-operand sign control
// assumes operands are already registered or stable for the cycle
module dmac_mul
  import dmac_pkg::*;
#(
  parameter int W = 9
) (
  input wire logic [W-1:0] a_in, // operand a
  input wire logic [W-1:0] b_in, // operand b
  input wire logic sa_in, // operand a is signed
  input wire logic sb_in, // operand b is signed
  output logic [2*W-1:0] p_out // product
);
  logic signed [2*W+1:0] full;

  if (W < 2) begin : g_bad_width
    $error("dmac_mul width too small");
  end

  // one extra bit per operand makes mixed signs exact; result signed
  // whenever either side is signed, unsigned otherwise
  assign full = $signed({sa_in & a_in[W-1], a_in}) *
                $signed({sb_in & b_in[W-1], b_in});
  assign p_out = full[2*W-1:0];
endmodule

//--- core/dmac_pkg.sv
// package for the dsp multiply-accumulate block: register map, fields,
// reset values, modes and shared arithmetic helpers
// assumes one clock and a classic wishbone register port
package dmac_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [31:0] REG_CFG = 32'h0000_0000;
  localparam logic [31:0] REG_SHIFT = 32'h0000_0004;
  localparam logic [31:0] REG_GRP = 32'h0000_0008;
  localparam logic [31:0] REG_STAT = 32'h0000_000C;
  // ----------------------------------------------------------------
  // field positions in the configuration and group registers
  // ----------------------------------------------------------------
  localparam int CFG_MODE = 0;
  localparam int CFG_SIZE = 2;
  localparam int CFG_INA = 4;
  localparam int CFG_INB = 5;
  localparam int CFG_PIPE = 6;
  localparam int CFG_OUTR = 7;
  localparam int CFG_SGD = 8;
  localparam int CFG_ASD = 10;
  localparam int CFG_SLD = 12;
  localparam int GRP_A = 0;
  localparam int GRP_B = 2;
  localparam int GRP_P = 4;
  localparam int GRP_O = 6;
  // ----------------------------------------------------------------
  // reset values and widths
  // ----------------------------------------------------------------
  localparam logic [13:0] CFG_RST = 14'h0000;
  localparam logic [15:0] SHIFT_RST = 16'h0000;
  localparam logic [7:0] GRP_RST = 8'h00;
  localparam int ACC_W = 52;
  localparam int SUM_W = 53;
  localparam int OP_W = 72;
  localparam int RES_W = 144;
  localparam int CHAIN_LEN_MAX = 224;
  localparam logic [1:0] SZ_SMALL = 2'h0;
  localparam logic [1:0] SZ_MED = 2'h1;

  typedef enum logic [1:0] {
    MODE_MUL = 2'h0,
    MODE_MAC = 2'h1,
    MODE_ADD2 = 2'h2,
    MODE_ADD4 = 2'h3
  } dmac_mode_t;

  // extend the low w bits of v to the common arithmetic width
  function automatic logic [SUM_W-1:0] dmac_ext(input logic [71:0] v,
                                                input int w,
                                                input logic s);
    logic [SUM_W-1:0] r;
    r = '0;
    for (int i = 0; i < SUM_W; i++) begin
      r[i] = (i < w) ? v[i] : (s & v[w-1]);
    end
    return r;
  endfunction
endpackage

//--- core/dmac_top.sv
// dsp multiply-accumulate block: input registers and shift chains,
// multipliers, pipeline, adders, accumulators, summation, output select
// assumes one clock, wishbone master for configuration, fabric logic
// driving operands and control pins synchronously to clk_in
module dmac_top
  import dmac_pkg::*;
(
  input wire logic clk_in, // block clock
  input wire logic reset_in, // synchronous reset, high
  input wire logic [31:0] wb_adr_in, // wishbone address
  input wire logic [31:0] wb_dat_in, // wishbone write data
  input wire logic [3:0] wb_sel_in, // wishbone byte selects
  input wire logic wb_we_in, // wishbone write
  input wire logic wb_cyc_in, // wishbone cycle
  input wire logic wb_stb_in, // wishbone strobe
  output logic [31:0] wb_dat_out, // wishbone read data
  output logic wb_ack_out, // wishbone acknowledge
  input wire logic [OP_W-1:0] a_data_in, // parallel operands a
  input wire logic [OP_W-1:0] b_data_in, // parallel operands b
  input wire logic [17:0] operand_a_chain_in, // chain in, a
  input wire logic [17:0] operand_b_chain_in, // chain in, b
  input wire logic sign_a_in, // operand a signed
  input wire logic sign_b_in, // operand b signed
  input wire logic [1:0] addnsub_in, // high add, low subtract
  input wire logic [1:0] accum_sload_in, // load accumulators
  input wire logic [3:0] ena_set_in, // four clock enables
  input wire logic [3:0] clr_set_in, // four asynchronous clears
  output logic [RES_W-1:0] result_out, // block result
  output logic [1:0] overflow_out, // accumulator overflow
  output logic [17:0] operand_a_chain_out, // chain out, a
  output logic [17:0] operand_b_chain_out // chain out, b
);
  // ----------------------------------------------------------------
  // configuration registers and wishbone slave
  // ----------------------------------------------------------------
  logic [13:0] cfg_q;
  logic [15:0] shift_q;
  logic [7:0] grp_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic hit;
  logic [31:0] rd_mux;
  logic [1:0] ovf_q;
  logic [1:0] size_e;
  dmac_mode_t mode_e;

  // merge write data into a register under the byte selects
  function automatic logic [31:0] wb_merge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign hit = (wb_adr_in[31:4] == 28'h0000000);

  // read decode; unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit) begin
      case ({28'h0000000, wb_adr_in[3:2], 2'h0})
        REG_CFG: rd_mux = {18'h00000, cfg_q};
        REG_SHIFT: rd_mux = {16'h0000, shift_q};
        REG_GRP: rd_mux = {24'h000000, grp_q};
        REG_STAT: rd_mux = {26'h0, mode_e, size_e, ovf_q};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // ack one cycle after the request, for one cycle only
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= wb_cyc_in & wb_stb_in & ~ack_q;
      rdat_q <= rd_mux;
    end
  end

  // a write lands on the edge where the master sees ack
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cfg_q <= CFG_RST;
      shift_q <= SHIFT_RST;
      grp_q <= GRP_RST;
    end else if (wb_cyc_in & wb_stb_in & wb_we_in & ack_q & hit) begin
      case ({28'h0000000, wb_adr_in[3:2], 2'h0})
        REG_CFG: cfg_q <= 14'(wb_merge({18'h0, cfg_q}, wb_dat_in,
                                       wb_sel_in));
        REG_SHIFT: shift_q <= 16'(wb_merge({16'h0, shift_q}, wb_dat_in,
                                           wb_sel_in));
        REG_GRP: grp_q <= 8'(wb_merge({24'h0, grp_q}, wb_dat_in,
                                      wb_sel_in));
        default: ;
      endcase
    end
  end

  assign wb_ack_out = ack_q;
  assign wb_dat_out = rdat_q;

  // ----------------------------------------------------------------
  // effective configuration
  // ----------------------------------------------------------------
  logic sz_large;
  logic sz_med;
  logic [7:0] sh_a;
  logic [7:0] sh_b;
  logic in_a_e;
  logic in_b_e;
  logic mac_on;

  // the large multiplier only runs plain, without a chain; one mode
  // governs the whole block so no per-lane mode is kept
  assign sz_large = cfg_q[CFG_SIZE+1];
  assign sz_med = (cfg_q[CFG_SIZE +: 2] == SZ_MED);
  assign size_e = cfg_q[CFG_SIZE +: 2];
  assign mode_e = sz_large ? MODE_MUL :
                  dmac_mode_t'(cfg_q[CFG_MODE +: 2]);
  assign mac_on = (mode_e == MODE_MAC);

  // map per-lane chain bits onto 9-bit slices
  function automatic logic [7:0] sl_mask(input logic [7:0] m,
                                         input logic med,
                                         input logic big);
    logic [7:0] r;
    r = 8'h00;
    for (int j = 0; j < 8; j++) begin
      r[j] = ~big & (med ? m[j>>1] : m[j]);
    end
    return r;
  endfunction

  assign sh_a = sl_mask(shift_q[7:0], sz_med, sz_large);
  assign sh_b = sl_mask(shift_q[15:8], sz_med, sz_large);
  // a chained slice needs its register, whatever the enable bit says
  assign in_a_e = cfg_q[CFG_INA] | (|sh_a);
  assign in_b_e = cfg_q[CFG_INB] | (|sh_b);

  // ----------------------------------------------------------------
  // selected control sets
  // ----------------------------------------------------------------
  logic clr_a, ena_a, clr_b, ena_b, clr_p, ena_p, clr_o, ena_o;
  assign clr_a = clr_set_in[grp_q[GRP_A +: 2]];
  assign ena_a = ena_set_in[grp_q[GRP_A +: 2]];
  assign clr_b = clr_set_in[grp_q[GRP_B +: 2]];
  assign ena_b = ena_set_in[grp_q[GRP_B +: 2]];
  assign clr_p = clr_set_in[grp_q[GRP_P +: 2]];
  assign ena_p = ena_set_in[grp_q[GRP_P +: 2]];
  assign clr_o = clr_set_in[grp_q[GRP_O +: 2]];
  assign ena_o = ena_set_in[grp_q[GRP_O +: 2]];

  // ----------------------------------------------------------------
  // input registers and shift chains
  // ----------------------------------------------------------------
  logic [OP_W-1:0] a_q, b_q, a_d, b_d, a_sh, b_sh, a_op, b_op;
  logic sa_q, sb_q, sa_m, sb_m;

  // a chain step moves one lane: 9 bits small, 18 bits medium; a lane
  // whose bit is clear loads in parallel and so ends the chain there
  always_comb begin
    a_sh = sz_med ? {a_q[53:0], operand_a_chain_in} :
                    {a_q[62:0], operand_a_chain_in[8:0]};
    b_sh = sz_med ? {b_q[53:0], operand_b_chain_in} :
                    {b_q[62:0], operand_b_chain_in[8:0]};
    for (int j = 0; j < 8; j++) begin
      a_d[j*9 +: 9] = sh_a[j] ? a_sh[j*9 +: 9] : a_data_in[j*9 +: 9];
      b_d[j*9 +: 9] = sh_b[j] ? b_sh[j*9 +: 9] : b_data_in[j*9 +: 9];
    end
  end

  always_ff @(posedge clk_in or posedge clr_a) begin
    if (clr_a) begin
      a_q <= '0;
      sa_q <= 1'b0;
    end else if (reset_in) begin
      a_q <= '0;
      sa_q <= 1'b0;
    end else if (ena_a) begin
      a_q <= a_d;
      sa_q <= sign_a_in;
    end
  end

  always_ff @(posedge clk_in or posedge clr_b) begin
    if (clr_b) begin
      b_q <= '0;
      sb_q <= 1'b0;
    end else if (reset_in) begin
      b_q <= '0;
      sb_q <= 1'b0;
    end else if (ena_b) begin
      b_q <= b_d;
      sb_q <= sign_b_in;
    end
  end

  // signs follow their operand through the input register
  assign a_op = in_a_e ? a_q : a_data_in;
  assign b_op = in_b_e ? b_q : b_data_in;
  assign sa_m = in_a_e ? sa_q : sign_a_in;
  assign sb_m = in_b_e ? sb_q : sign_b_in;
  assign operand_a_chain_out = sz_med ? a_q[71:54] : {9'h000, a_q[71:63]};
  assign operand_b_chain_out = sz_med ? b_q[71:54] : {9'h000, b_q[71:63]};

  // ----------------------------------------------------------------
  // multipliers
  // ----------------------------------------------------------------
  logic [17:0] ps [8];
  logic [35:0] pm [4];
  logic [17:0] ma [4];
  logic [17:0] mb [4];
  logic [3:0] msa, msb;
  logic [71:0] p72;
  logic [RES_W-1:0] prod;

  for (genvar i = 0; i < 8; i++) begin : g_small
    dmac_mul #(.W(9)) u_mul (
      .a_in(a_op[i*9 +: 9]),
      .b_in(b_op[i*9 +: 9]),
      .sa_in(sa_m),
      .sb_in(sb_m),
      .p_out(ps[i])
    );
  end

  // in large size the four medium units take the operand halves; only
  // the upper halves carry a sign
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      ma[k] = sz_large ? a_op[(k[0] ? 18 : 0) +: 18] : a_op[k*18 +: 18];
      mb[k] = sz_large ? b_op[(k[1] ? 18 : 0) +: 18] : b_op[k*18 +: 18];
      msa[k] = sz_large ? (sa_m & k[0]) : sa_m;
      msb[k] = sz_large ? (sb_m & k[1]) : sb_m;
    end
  end

  for (genvar k = 0; k < 4; k++) begin : g_med
    dmac_mul #(.W(18)) u_mul (
      .a_in(ma[k]),
      .b_in(mb[k]),
      .sa_in(msa[k]),
      .sb_in(msb[k]),
      .p_out(pm[k])
    );
  end

  // shift-and-add of the partial products, exact modulo 2**72
  assign p72 = {36'h0, pm[0]} +
               ({{36{sa_m & pm[1][35]}}, pm[1]} << 18) +
               ({{36{sb_m & pm[2][35]}}, pm[2]} << 18) +
               {pm[3], 36'h0};

  always_comb begin
    prod = {72'h0, p72};
    if (!sz_large) begin
      for (int k = 0; k < 4; k++) begin
        prod[k*36 +: 36] = sz_med ? pm[k] : {ps[2*k+1], ps[2*k]};
      end
    end
  end

  // ----------------------------------------------------------------
  // pipeline register and control delays
  // ----------------------------------------------------------------
  logic [RES_W-1:0] pq;
  logic [1:0] sg_add, as_e, sl_e;
  logic sgn;

  // in large size this same register is the multiplier's inner stage
  dmac_dly #(.W(RES_W)) u_pipe (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .stages_in({1'b0, cfg_q[CFG_PIPE]}),
    .ena_in(ena_p),
    .clr_in(clr_p),
    .d_in(prod),
    .q_out(pq)
  );

  // adder copies of the sign pins share the operand a control set
  dmac_dly #(.W(2)) u_sgn (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .stages_in(cfg_q[CFG_SGD +: 2]),
    .ena_in(ena_a),
    .clr_in(clr_a),
    .d_in({sign_b_in, sign_a_in}),
    .q_out(sg_add)
  );

  dmac_dly #(.W(2)) u_asub (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .stages_in(cfg_q[CFG_ASD +: 2]),
    .ena_in(ena_o),
    .clr_in(clr_o),
    .d_in(addnsub_in),
    .q_out(as_e)
  );

  dmac_dly #(.W(2)) u_sload (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .stages_in(cfg_q[CFG_SLD +: 2]),
    .ena_in(ena_o),
    .clr_in(clr_o),
    .d_in(accum_sload_in),
    .q_out(sl_e)
  );

  assign sgn = sg_add[0] | sg_add[1];

  // ----------------------------------------------------------------
  // adder/subtractors and summation
  // ----------------------------------------------------------------
  logic [SUM_W-1:0] e [8];
  logic [SUM_W-1:0] r [4];
  logic [SUM_W-1:0] sm [2];

  always_comb begin
    for (int k = 0; k < 8; k++) begin
      e[k] = sz_med ? dmac_ext({36'h0, pq[(k&3)*36 +: 36]}, 36, sgn) :
                      dmac_ext({54'h0, pq[k*18 +: 18]}, 18, sgn);
    end
    // small: pin 0 steers the bottom two adders, pin 1 the top two
    for (int k = 0; k < 4; k++) begin
      if (as_e[sz_med ? k[0] : k[1]]) begin
        r[k] = e[2*k] + e[2*k+1];
      end else begin
        r[k] = e[2*k] - e[2*k+1];
      end
    end
    sm[0] = r[0] + r[1];
    sm[1] = r[2] + r[3];
  end

  // ----------------------------------------------------------------
  // accumulators
  // ----------------------------------------------------------------
  logic [ACC_W-1:0] acc_q [2];
  logic [SUM_W-1:0] src [2];
  logic [SUM_W-1:0] asum [2];
  logic [1:0] ovf_d;

  // each accumulator hears one multiplier; sub-blocks 0 and 2 idle
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      src[k] = sz_med ? e[2*k+1] : e[4*k+2];
      if (as_e[k]) begin
        asum[k] = dmac_ext({20'h0, acc_q[k]}, ACC_W, sgn) + src[k];
      end else begin
        asum[k] = dmac_ext({20'h0, acc_q[k]}, ACC_W, sgn) - src[k];
      end
      // signed: carry into the top differs; unsigned: carry or borrow
      ovf_d[k] = ~sl_e[k] & (sgn ? (asum[k][52] ^ asum[k][51]) :
                                   asum[k][52]);
    end
  end

  // the accumulator always runs registered, on the output control set
  always_ff @(posedge clk_in or posedge clr_o) begin
    if (clr_o) begin
      acc_q[0] <= '0;
      acc_q[1] <= '0;
      ovf_q <= 2'h0;
    end else if (reset_in | ~mac_on) begin
      acc_q[0] <= '0;
      acc_q[1] <= '0;
      ovf_q <= 2'h0;
    end else if (ena_o) begin
      for (int k = 0; k < 2; k++) begin
        acc_q[k] <= sl_e[k] ? src[k][ACC_W-1:0] :
                              asum[k][ACC_W-1:0];
      end
      ovf_q <= ovf_d;
    end
  end

  assign overflow_out = ovf_q;

  // ----------------------------------------------------------------
  // output select and output registers
  // ----------------------------------------------------------------
  logic [RES_W-1:0] res_d;

  always_comb begin
    res_d = pq;
    case (mode_e)
      MODE_MUL: res_d = pq;
      MODE_MAC: res_d = {40'h0, acc_q[1], acc_q[0]};
      MODE_ADD2: begin
        for (int k = 0; k < 4; k++) begin
          res_d[k*36 +: 36] = sz_med ? 36'h0 : r[k][35:0];
        end
        if (sz_med) begin
          res_d = {{19{r[1][52]}}, r[1], {19{r[0][52]}}, r[0]};
        end
      end
      MODE_ADD4: begin
        res_d = {{19{sm[1][52]}}, sm[1], {19{sm[0][52]}}, sm[0]};
        if (sz_med) begin
          res_d[143:72] = 72'h0;
        end
      end
      default: res_d = pq;
    endcase
  end

  dmac_dly #(.W(RES_W)) u_out (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .stages_in({1'b0, cfg_q[CFG_OUTR] & ~mac_on}),
    .ena_in(ena_o),
    .clr_in(clr_o),
    .d_in(res_d),
    .q_out(result_out)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  sequence wb_req_s;
    wb_cyc_in & wb_stb_in & ~ack_q;
  endsequence
  sequence wb_ack_s;
    ack_q ##1 ~ack_q;
  endsequence

  wb_ack_pulse_a: assert property (wb_req_s |=> wb_ack_s)
    else $error("wishbone ack not a one-cycle answer");

  small_unsig_a: assert property (
    (!sz_med && !sz_large && !sa_m && !sb_m) |->
      ps[0] == 18'(a_op[8:0] * b_op[8:0]))
    else $error("unsigned small product wrong");

  small_sign_a: assert property (
    (!sz_med && !sz_large && sa_m && sb_m) |->
      $signed(ps[1]) == $signed(a_op[17:9]) * $signed(b_op[17:9]))
    else $error("signed small product wrong");

  large_prod_a: assert property (
    (sz_large && !sa_m && !sb_m) |->
      p72 == 72'(a_op[35:0] * b_op[35:0]))
    else $error("large product wrong");

  large_noshift_a: assert property (
    sz_large |-> (sh_a == 8'h00 && sh_b == 8'h00))
    else $error("chain active in large size");

  chain_step_a: assert property (
    (ena_a && !clr_a && !sz_med && sh_a[7]) ##1 !clr_a |->
      a_q[71:63] == $past(a_q[62:54]))
    else $error("chain did not step");

  acc_load_a: assert property (
    disable iff (reset_in || clr_o)
    (mac_on && ena_o && sl_e[0]) |=>
      acc_q[0] == $past(src[0][ACC_W-1:0]) && ovf_q[0] == 1'b0)
    else $error("accumulator load failed");

  ovf_clear_a: assert property (
    disable iff (reset_in || clr_o)
    (mac_on && ena_o && !ovf_d[1]) |=> !overflow_out[1])
    else $error("overflow flag held");

  add_sub_a: assert property (
    (sz_med && !as_e[1]) |-> r[1] == SUM_W'(e[2] - e[3]))
    else $error("subtract not selected");

  sum4_a: assert property (
    (mode_e == MODE_ADD4) |-> sm[0] == SUM_W'(r[0] + r[1]))
    else $error("summation wrong");

  out_mac_a: assert property (
    mac_on |-> result_out[103:52] == acc_q[1])
    else $error("mac output not routed");
endmodule

//--- verification/dmac_fabric.sv
// fabric model: keeps the block's overflow pulses for software
// assumes overflow_in is the block's registered flag
module dmac_fabric (
  input wire logic clk_in, // block clock
  input wire logic reset_in, // synchronous reset
  input wire logic [1:0] overflow_in, // block flags
  output logic [1:0] ovf_held_out // held flags
);
  timeunit 1ns;
  timeprecision 1ps;
  // the flag is not sticky, so it is held here until reset
  always_ff @(posedge clk_in) begin
    if (reset_in) ovf_held_out <= 2'h0;
    else ovf_held_out <= ovf_held_out | overflow_in;
  end
endmodule

//--- verification/testbench.sv
// testbench: register access over wishbone, product and mac checks
// assumes no input or output registers after reset
module testbench;
  import dmac_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, reset_in = 1, cyc = 0, stb = 0, we = 0;
  logic [31:0] adr = 0, wdat = 0, rd, wb_dat_out;
  logic wb_ack_out, sa = 0, sb = 0;
  logic [OP_W-1:0] a = 0, b = 0;
  logic [1:0] addnsub = 2'h3, sload = 0, ovf, held;
  logic [3:0] clr = 0;
  logic [RES_W-1:0] res;
  logic [17:0] cha, chb, chin = 0;
  int fails = 0, checked = 0;
  // half period of 2 ns gives 250 MHz
  always #2 clk_in = ~clk_in;
  dmac_top dmac_top_inst (.clk_in(clk_in), .reset_in(reset_in),
    .wb_adr_in(adr), .wb_dat_in(wdat), .wb_sel_in(4'hF), .wb_we_in(we),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .a_data_in(a), .b_data_in(b),
    .operand_a_chain_in(chin), .operand_b_chain_in(chin),
    .sign_a_in(sa), .sign_b_in(sb), .addnsub_in(addnsub),
    .accum_sload_in(sload), .ena_set_in(4'hF), .clr_set_in(clr),
    .result_out(res), .overflow_out(ovf), .operand_a_chain_out(cha),
    .operand_b_chain_out(chb));
  dmac_fabric dmac_fabric_inst (.clk_in(clk_in), .reset_in(reset_in),
    .overflow_in(ovf), .ovf_held_out(held));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task chk(input logic [RES_W-1:0] got, input logic [RES_W-1:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // classic cycle: hold until ack is sampled, then release
  task wb(input logic w, input logic [31:0] ad, input logic [31:0] d);
    @(posedge clk_in);
    cyc <= 1; stb <= 1; we <= w; adr <= ad; wdat <= d;
    // the watchdog alone bounds this wait
    do begin
      @(posedge clk_in);
    end while (wb_ack_out !== 1'b1);
    rd = wb_dat_out;
    cyc <= 0; stb <= 0;
  endtask
  task test_done;
    $display("checks %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // bounds a hang; the run needs well under a thousand cycles
  initial begin
    #20000;
    fails++;
    test_done;
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_in);
    reset_in <= 0;
    wb(0, REG_CFG, 0);
    chk(rd, 0);
    wb(0, 32'h40, 0);
    chk(rd, 0);
    // small lane 0: 1FF times 2, sign of a only, then unsigned
    a <= 72'h1FF; b <= 72'h2; sa <= 1;
    @(posedge clk_in);
    chk(res[17:0], 18'h3FFFE);
    sa <= 0;
    @(posedge clk_in);
    chk(res[17:0], 18'h003FE);
    // medium mac on lane 1: load, add, subtract past zero, reload, clear;
    // outputs are read at the edge, before that edge's update lands
    wb(1, REG_CFG, 32'h5);
    wb(0, REG_CFG, 0);
    chk(rd[13:0], 14'h5);
    a <= 72'h3 << 18; b <= 72'h4 << 18; sload <= 2'h1;
    @(posedge clk_in);
    sload <= 0;
    @(posedge clk_in);
    chk(res, 12);
    addnsub <= 2'h2;
    @(posedge clk_in);
    chk(res, 24);
    @(posedge clk_in);
    chk(res, 12);
    @(posedge clk_in);
    chk(res, 0);
    chk(held, 0);
    sload <= 2'h1;
    @(posedge clk_in);
    chk(res, 144'hF_FFFF_FFFF_FFF4);
    chk(ovf, 2'h1);
    sload <= 0; addnsub <= 2'h3;
    @(posedge clk_in);
    chk(res, 12);
    chk(ovf, 0);
    chk(held, 2'h1);
    // clear lands at once, after the add that this edge made
    clr <= 4'h1;
    @(posedge clk_in);
    chk(res, 0);
    clr <= 0; a <= 0;
    // small chain over all eight a lanes, b parallel on lane 7
    wb(1, REG_CFG, 0);
    wb(1, REG_SHIFT, 32'hFF);
    chin <= 18'h5; b <= 72'h3 << 63;
    @(posedge clk_in);
    chin <= 0;
    repeat (7) @(posedge clk_in);
    chk(cha, 0);
    @(posedge clk_in);
    chk(cha, 18'h5);
    chk(chb, 18'h3);
    chk(res, 144'hF << 126);
    // small four-product sums, then the upper adder pair subtracting
    wb(1, REG_SHIFT, 0);
    wb(1, REG_CFG, 32'h3);
    a <= {8{9'h1}}; b <= {8{9'h2}};
    @(posedge clk_in);
    chk(res, {72'h8, 72'h8});
    addnsub <= 2'h1;
    @(posedge clk_in);
    chk(res, 144'h8);
    // large size: one unsigned 36-bit product
    wb(1, REG_CFG, 32'h8);
    a <= 72'hF_FFFF_FFFF; b <= 72'h2;
    @(posedge clk_in);
    chk(res, 144'h1F_FFFF_FFFE);
    test_done;
  end
endmodule
